// [design/elsc_pkg.sv]
package elsc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int WORD_LSB = 2;
  localparam logic [ADDR_W-1:0] OFF_LINK_CAP = 8'hbc;
  localparam logic [ADDR_W-1:0] OFF_LINK_CTRL_STAT = 8'hc0;
  localparam logic [ADDR_W-1:0] OFF_SLOT_CAP = 8'hc4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAP_SPEED_LSB = 0;
  localparam int CAP_WIDTH_LSB = 4;
  localparam int CAP_ASPM_LSB = 10;
  localparam int CAP_L0S_LAT_LSB = 12;
  localparam int CAP_L1_LAT_LSB = 15;
  localparam int CTL_ASPM_LSB = 0;
  localparam int CTL_RCB_BIT = 3;
  localparam int CTL_DISABLE_BIT = 4;
  localparam int CTL_RETRAIN_BIT = 5;
  localparam int CTL_CCC_BIT = 6;
  localparam int CTL_ESYNC_BIT = 7;
  localparam int CTL_BYTE = 0;
  localparam int STA_SPEED_LSB = 16;
  localparam int STA_WIDTH_LSB = 20;
  localparam int STA_TERR_BIT = 26;
  localparam int STA_TRAINING_BIT = 27;
  localparam int STA_SCC_BIT = 28;
  localparam int SLOT_ATTN_BTN_BIT = 0;
  localparam int SLOT_MRL_BIT = 2;
  localparam int SLOT_ATTN_IND_BIT = 3;
  localparam int SLOT_PWR_IND_BIT = 4;
  localparam int SLOT_HP_CAP_BIT = 6;

  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [5:0] WIDTH_X2 = 6'h02;
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;
  localparam logic [5:0] WIDTH_X12 = 6'h0c;
  localparam logic [5:0] WIDTH_X16 = 6'h10;
  localparam logic [5:0] WIDTH_X32 = 6'h20;
  localparam logic [1:0] ASPM_L0S_L1 = 2'h3;
  localparam logic [1:0] ASPM_OFF = 2'h0;
  localparam logic [2:0] L0S_EXIT_LAT = 3'h3;
  localparam logic [2:0] L1_EXIT_LAT = 3'h0;
  localparam logic SCC_RESET = 1'b1;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic {ELSC_CAP_WAIT, ELSC_CAP_DONE} elsc_cap_e;

  function automatic logic elsc_word_is(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:WORD_LSB] == off[ADDR_W-1:WORD_LSB];
  endfunction : elsc_word_is

  function automatic logic elsc_mapped(input logic [ADDR_W-1:0] a);
    return elsc_word_is(a, OFF_LINK_CAP) || elsc_word_is(a, OFF_LINK_CTRL_STAT) ||
           elsc_word_is(a, OFF_SLOT_CAP);
  endfunction : elsc_mapped

  function automatic logic elsc_legal_width(input logic [5:0] w);
    return w == WIDTH_X1 || w == WIDTH_X2 || w == WIDTH_X4 || w == WIDTH_X8 ||
           w == WIDTH_X12 || w == WIDTH_X16 || w == WIDTH_X32;
  endfunction : elsc_legal_width

endpackage : elsc_pkg

// [design/elsc_reg_if.sv]
`timescale 1ns/1ps
interface elsc_reg_if;
  import elsc_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_err;

  modport bus_end (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_err, rd_data, rd_err
  );
  modport regs_end (
    input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_err, rd_data, rd_err
  );
endinterface : elsc_reg_if

// [design/elsc_strap_cap.sv]
`timescale 1ns/1ps
module elsc_strap_cap #(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Strap pins and captured value
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] cap_out,
  output logic cap_valid
);
  import elsc_pkg::*;

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [1:0] settle;
  elsc_cap_e state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // The strap is taken once, after the synchroniser has refilled past reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ELSC_CAP_WAIT;
      settle <= '0;
      cap_out <= RESET_VAL;
    end else if (ce) begin
      case (state)
        ELSC_CAP_WAIT: begin
          if (settle == STRAP_SETTLE) begin
            cap_out <= sync2;
            state <= ELSC_CAP_DONE;
          end else begin
            settle <= settle + 2'h1;
          end
        end
        ELSC_CAP_DONE: begin
          state <= ELSC_CAP_DONE;
        end
        default: begin
          state <= ELSC_CAP_WAIT;
        end
      endcase
    end
  end

  assign cap_valid = (state == ELSC_CAP_DONE);

  a_strap_loaded: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && state == ELSC_CAP_WAIT && settle == STRAP_SETTLE |=> cap_valid &&
      cap_out == $past(sync2))
    else $error("strap value not loaded on capture");
endmodule : elsc_strap_cap

// [design/elsc_axil_slave.sv]
`timescale 1ns/1ps
module elsc_axil_slave (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Write address and data
  input wire logic [elsc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [elsc_pkg::DATA_W-1:0] wdata,
  input wire logic [elsc_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read
  input wire logic [elsc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [elsc_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  elsc_reg_if.bus_end regs
);
  import elsc_pkg::*;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic do_write;

  // Ready is withheld while the clock enable is low so no beat is lost.
  assign awready = ce & ~aw_held & ~bvalid;
  assign wready = ce & ~w_held & ~bvalid;
  assign arready = ce & ~rvalid;
  assign do_write = ce & aw_held & w_held & ~bvalid;

  assign regs.wr_en = do_write;
  assign regs.wr_addr = aw_addr;
  assign regs.wr_data = w_data;
  assign regs.wr_strb = w_strb;
  assign regs.rd_en = arvalid & arready;
  assign regs.rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= regs.wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (regs.rd_en) begin
        rvalid <= 1'b1;
        rdata <= regs.rd_data;
        rresp <= regs.rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : elsc_axil_slave

// [design/elsc_regs.sv]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module elsc_regs #(
  parameter logic [5:0] MAX_WIDTH = elsc_pkg::WIDTH_X1
) (
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [elsc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [elsc_pkg::DATA_W-1:0] wdata,
  input wire logic [elsc_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [elsc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [elsc_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Strap pins
  input wire logic hotplug_strap,
  input wire logic forward_strap,
  // Link training state from the link core
  input wire logic [5:0] trained_width,
  input wire logic train_error,
  input wire logic training,
  // Link controls to the link core
  output logic [1:0] aspm_ctrl,
  output logic link_disable,
  output logic retrain_link,
  output logic common_clock_cfg,
  output logic extended_sync,
  output logic hotplug_active,
  output logic strap_ready
);
  import elsc_pkg::*;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_RESET = 2'h2;

  elsc_reg_if regs ();

  logic [1:0] strap_pins;
  logic [1:0] strap_val;
  logic hp_enabled;
  logic forward;

  assign strap_pins = {forward_strap, hotplug_strap};

  // Forward is assumed until the strap is known, so the direction-locked
  // controls cannot be written during the settle window.
  elsc_strap_cap #(
    .W(2),
    .RESET_VAL(STRAP_RESET)
  ) u_strap (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_in(strap_pins),
    .cap_out(strap_val),
    .cap_valid(strap_ready)
  );

  assign hp_enabled = strap_val[0];
  assign forward = strap_val[1];
  assign hotplug_active = hp_enabled & ~forward;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  elsc_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regs(regs.bus_end)
  );

  // ----------------------------------------------------------------
  // Link control
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic [7:0] ctrl_byte;

  assign ctrl_wr = regs.wr_en && elsc_word_is(regs.wr_addr, OFF_LINK_CTRL_STAT) &&
                   regs.wr_strb[CTL_BYTE];
  assign ctrl_byte = regs.wr_data[CTL_BYTE*8 +: 8];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aspm_ctrl <= ASPM_OFF;
    end else if (ce && ctrl_wr) begin
      aspm_ctrl <= ctrl_byte[CTL_ASPM_LSB +: 2];
    end
  end

  // Stored values are dropped when forward so a later read never shows them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_disable <= 1'b0;
      retrain_link <= 1'b0;
    end else if (ce) begin
      if (forward) begin
        link_disable <= 1'b0;
        retrain_link <= 1'b0;
      end else if (ctrl_wr) begin
        link_disable <= ctrl_byte[CTL_DISABLE_BIT];
        retrain_link <= ctrl_byte[CTL_RETRAIN_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      common_clock_cfg <= 1'b0;
      extended_sync <= 1'b0;
    end else if (ce && ctrl_wr) begin
      common_clock_cfg <= ctrl_byte[CTL_CCC_BIT];
      extended_sync <= ctrl_byte[CTL_ESYNC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Link status
  // ----------------------------------------------------------------
  logic [5:0] neg_width;

  // A code outside the set is ignored so the field never shows a reserved code.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      neg_width <= WIDTH_X1;
    end else if (ce && elsc_legal_width(trained_width)) begin
      neg_width <= trained_width;
    end
  end

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] cap_word;
  logic [DATA_W-1:0] ctrl_stat_word;
  logic [DATA_W-1:0] slot_word;

  always_comb begin
    cap_word = '0;
    cap_word[CAP_SPEED_LSB +: 4] = SPEED_2G5;
    cap_word[CAP_WIDTH_LSB +: 6] = MAX_WIDTH;
    cap_word[CAP_ASPM_LSB +: 2] = ASPM_L0S_L1;
    cap_word[CAP_L0S_LAT_LSB +: 3] = L0S_EXIT_LAT;
    cap_word[CAP_L1_LAT_LSB +: 3] = L1_EXIT_LAT;
  end

  always_comb begin
    ctrl_stat_word = '0;
    ctrl_stat_word[CTL_ASPM_LSB +: 2] = aspm_ctrl;
    ctrl_stat_word[CTL_RCB_BIT] = 1'b0;
    ctrl_stat_word[CTL_DISABLE_BIT] = link_disable & ~forward;
    ctrl_stat_word[CTL_RETRAIN_BIT] = retrain_link & ~forward;
    ctrl_stat_word[CTL_CCC_BIT] = common_clock_cfg;
    ctrl_stat_word[CTL_ESYNC_BIT] = extended_sync;
    ctrl_stat_word[STA_SPEED_LSB +: 4] = SPEED_2G5;
    ctrl_stat_word[STA_WIDTH_LSB +: 6] = neg_width;
    ctrl_stat_word[STA_TERR_BIT] = train_error;
    ctrl_stat_word[STA_TRAINING_BIT] = training;
    ctrl_stat_word[STA_SCC_BIT] = SCC_RESET;
  end

  // The strap value sets these bits; they are zero until it has been taken.
  always_comb begin
    slot_word = '0;
    slot_word[SLOT_ATTN_BTN_BIT] = hotplug_active;
    slot_word[SLOT_MRL_BIT] = hotplug_active;
    slot_word[SLOT_ATTN_IND_BIT] = hotplug_active;
    slot_word[SLOT_PWR_IND_BIT] = hotplug_active;
    slot_word[SLOT_HP_CAP_BIT] = hotplug_active;
  end

  always_comb begin
    regs.rd_data = '0;
    if (elsc_word_is(regs.rd_addr, OFF_LINK_CAP)) begin
      regs.rd_data = cap_word;
    end else if (elsc_word_is(regs.rd_addr, OFF_LINK_CTRL_STAT)) begin
      regs.rd_data = ctrl_stat_word;
    end else if (elsc_word_is(regs.rd_addr, OFF_SLOT_CAP)) begin
      regs.rd_data = slot_word;
    end
  end

  assign regs.rd_err = ~elsc_mapped(regs.rd_addr);
  assign regs.wr_err = ~elsc_mapped(regs.wr_addr);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_max_speed_read: assert property (
    regs.rd_en && elsc_word_is(araddr, OFF_LINK_CAP) |=>
      rvalid && rdata[CAP_SPEED_LSB +: 4] == SPEED_2G5)
    else $error("maximum speed field wrong");

  a_max_width_read: assert property (
    regs.rd_en && elsc_word_is(araddr, OFF_LINK_CAP) |=>
      rdata[CAP_WIDTH_LSB +: 6] == MAX_WIDTH && elsc_legal_width(MAX_WIDTH))
    else $error("maximum width field wrong");

  a_aspm_support: assert property (
    regs.rd_en && elsc_word_is(araddr, OFF_LINK_CAP) |=>
      rdata[CAP_ASPM_LSB +: 2] == ASPM_L0S_L1 && rresp == RESP_OKAY)
    else $error("power-state support field wrong");

  a_aspm_write: assert property (
    ce && ctrl_wr |=> aspm_ctrl == $past(ctrl_byte[CTL_ASPM_LSB +: 2]))
    else $error("power-state control not written");

  a_aspm_hold: assert property (
    !(ce && ctrl_wr) |=> $stable(aspm_ctrl))
    else $error("power-state control changed without write");

  a_rcb_zero: assert property (
    regs.rd_en && elsc_word_is(araddr, OFF_LINK_CTRL_STAT) |=> !rdata[CTL_RCB_BIT])
    else $error("completion boundary bit not zero");

  a_forward_locked: assert property (
    ce && forward |=> !link_disable && !retrain_link)
    else $error("direction-locked control set in forward");

  a_reverse_write: assert property (
    ce && ctrl_wr && !forward |=> link_disable == $past(ctrl_byte[CTL_DISABLE_BIT]) &&
      retrain_link == $past(ctrl_byte[CTL_RETRAIN_BIT]))
    else $error("direction-locked control not written in reverse");

  a_neg_speed_read: assert property (
    regs.rd_en && elsc_word_is(araddr, OFF_LINK_CTRL_STAT) |=>
      rdata[STA_SPEED_LSB +: 4] == SPEED_2G5)
    else $error("negotiated speed field wrong");

  a_slot_bits: assert property (
    regs.rd_en && elsc_word_is(araddr, OFF_SLOT_CAP) |=>
      rdata[SLOT_HP_CAP_BIT] == $past(hp_enabled && !forward) &&
      rdata[SLOT_ATTN_BTN_BIT] == rdata[SLOT_PWR_IND_BIT])
    else $error("hot-plug slot bits wrong");

  a_slot_before_strap: assert property (
    !strap_ready |-> slot_word == '0)
    else $error("hot-plug bits set before strap capture");

  a_width_track: assert property (
    ce && elsc_legal_width(trained_width) |=> neg_width == $past(trained_width))
    else $error("trained width not tracked");

  a_width_legal: assert property (
    elsc_legal_width(neg_width))
    else $error("trained width field shows reserved code");

  a_read_latency: assert property (
    regs.rd_en |=> rvalid && rresp == ($past(regs.rd_err) ? RESP_SLVERR : RESP_OKAY))
    else $error("read answer late or wrong");

  c_ctrl_write: cover property (ctrl_wr ##[1:4] bvalid && bready);
  c_cap_read: cover property (regs.rd_en && elsc_word_is(araddr, OFF_LINK_CAP));
  c_unmapped: cover property (rvalid && rresp == RESP_SLVERR);
  c_hotplug_on: cover property ($rose(hotplug_active));
endmodule : elsc_regs

// [verif/elsc_link_partner.sv]
`timescale 1ns/1ps
module elsc_link_partner #(
  parameter int TRAIN_CYC = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench stimulus
  input wire logic [5:0] target_width,
  input wire logic err_in,
  // Link state towards the registers
  output logic [5:0] trained_width,
  output logic train_error,
  output logic training
);
  import elsc_pkg::*;
  int cnt;

  // Mid-training the lane count is unsettled, so a changing illegal code is shown.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trained_width <= WIDTH_X1;
      training <= 1'b0;
      cnt <= 0;
    end else if (training && cnt == 0) begin
      training <= 1'b0;
      trained_width <= target_width;
    end else if (training) begin
      cnt <= cnt - 1;
      trained_width <= trained_width ^ 6'h01;
    end else if (target_width != trained_width) begin
      training <= 1'b1;
      cnt <= TRAIN_CYC;
      trained_width <= 6'h3f;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      train_error <= 1'b0;
    end else begin
      train_error <= err_in;
    end
  end
endmodule : elsc_link_partner

// [verif/express_link_slot_cap_regs_tb.sv]
`timescale 1ns/1ps
module express_link_slot_cap_regs_tb;
  import elsc_pkg::*;
  localparam logic [31:0] CAP_EXP = {14'h0, L1_EXIT_LAT, L0S_EXIT_LAT, ASPM_L0S_L1,
                                     WIDTH_X1, SPEED_2G5};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic hotplug_strap = 1'b0, forward_strap = 1'b1, err_in = 1'b0;
  logic [5:0] target_width = WIDTH_X1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, aspm_ctrl;
  logic [31:0] rdata;
  logic [5:0] trained_width;
  logic train_error, training, link_disable, retrain_link, common_clock_cfg, extended_sync;
  logic hotplug_active, strap_ready;
  int err_total = 0, n_compared = 0, cyc = 0, k, c, i;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [7:0] ctl;
  logic [5:0] prev;
  logic hp, fwd, rev, ae;
  logic [1:0] cfgs [3] = '{2'b11, 2'b10, 2'b00};
  logic [5:0] widths [7] = '{WIDTH_X2, WIDTH_X4, WIDTH_X8, WIDTH_X12, WIDTH_X16,
                             WIDTH_X32, WIDTH_X1};

  always #10 aclk = ~aclk;

  elsc_regs #(.MAX_WIDTH(WIDTH_X1)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hotplug_strap(hotplug_strap), .forward_strap(forward_strap),
    .trained_width(trained_width), .train_error(train_error), .training(training),
    .aspm_ctrl(aspm_ctrl), .link_disable(link_disable), .retrain_link(retrain_link),
    .common_clock_cfg(common_clock_cfg), .extended_sync(extended_sync),
    .hotplug_active(hotplug_active), .strap_ready(strap_ready)
  );

  elsc_link_partner #(.TRAIN_CYC(12)) u_part (
    .aclk(aclk), .aresetn(aresetn), .target_width(target_width), .err_in(err_in),
    .trained_width(trained_width), .train_error(train_error), .training(training)
  );

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] stat(input logic [5:0] w, input logic e, input logic t,
                                       input logic [7:0] cb);
    return {3'h0, SCC_RESET, t, e, w, SPEED_2G5, 8'h00, cb};
  endfunction : stat

  // Handshakes are sampled at the falling edge, where the values equal those of the next
  // rising edge, so no race with the design's own updates is possible.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd_word(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd_word

  task automatic boot(input logic h, input logic f);
    int n;
    @(posedge aclk);
    aresetn <= 1'b0;
    hotplug_strap <= h;
    forward_strap <= f;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    while (strap_ready !== 1'b1 && n < 8) begin
      @(negedge aclk);
      n++;
    end
    chk({31'h0, strap_ready}, 32'h1);
    chk({31'h0, hotplug_active}, {31'h0, h && !f});
  endtask : boot

  task automatic wait_train(input logic lvl);
    int n;
    n = 0;
    while (training !== lvl && n < 40) begin
      @(negedge aclk);
      n++;
    end
  endtask : wait_train

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    for (k = 0; k < 3; k++) begin
      {hp, fwd} = cfgs[k];
      rev = !fwd;
      ae = hp && rev;
      boot(hp, fwd);
      rd_word(OFF_LINK_CAP, rd, rs);
      chk(rd, CAP_EXP);
      rd_word(OFF_LINK_CTRL_STAT, rd, rs);
      chk(rd, stat(WIDTH_X1, 1'b0, 1'b0, 8'h00));
      wr(OFF_LINK_CAP, 32'hffffffff, 4'hf, rs);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      rd_word(OFF_LINK_CAP, rd, rs);
      chk(rd, CAP_EXP);
      wr(OFF_SLOT_CAP, 32'hffffffff, 4'hf, rs);
      rd_word(OFF_SLOT_CAP, rd, rs);
      chk(rd, {25'h0, ae, 1'b0, ae, ae, ae, 1'b0, ae});
      // Without the low byte lane the control byte must stay untouched.
      wr(OFF_LINK_CTRL_STAT, 32'hffffffff, 4'he, rs);
      rd_word(OFF_LINK_CTRL_STAT, rd, rs);
      chk(rd, stat(WIDTH_X1, 1'b0, 1'b0, 8'h00));
      wr(OFF_LINK_CTRL_STAT, 32'hffffffff, 4'hf, rs);
      ctl = {2'b11, rev, rev, 2'b00, 2'b11};
      rd_word(OFF_LINK_CTRL_STAT, rd, rs);
      chk(rd, stat(WIDTH_X1, 1'b0, 1'b0, ctl));
      chk({28'h0, link_disable, retrain_link, aspm_ctrl}, {28'h0, rev, rev, 2'h3});
      chk({30'h0, common_clock_cfg, extended_sync}, 32'h3);
      // A low clock enable must stall the bus and freeze the control byte.
      @(posedge aclk);
      ce <= 1'b0;
      fork
        wr(OFF_LINK_CTRL_STAT, 32'h00000001, 4'h1, rs);
        begin
          repeat (3) @(posedge aclk);
          @(negedge aclk);
          chk({29'h0, awready, wready, arready}, 32'h0);
          chk({30'h0, aspm_ctrl}, 32'h3);
          @(posedge aclk);
          ce <= 1'b1;
        end
      join
      rd_word(OFF_LINK_CTRL_STAT, rd, rs);
      chk(rd, stat(WIDTH_X1, 1'b0, 1'b0, 8'h01));
      chk({30'h0, common_clock_cfg, extended_sync}, 32'h0);
      for (c = 0; c < 4; c++) begin
        wr(OFF_LINK_CTRL_STAT, {30'h0, c[1:0]}, 4'h1, rs);
        rd_word(OFF_LINK_CTRL_STAT, rd, rs);
        chk(rd, stat(WIDTH_X1, 1'b0, 1'b0, {6'h0, c[1:0]}));
        chk({30'h0, aspm_ctrl}, {30'h0, c[1:0]});
      end
      rd_word(8'h10, rd, rs);
      chk(rd, 32'h0);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      wr(8'h10, 32'hffffffff, 4'hf, rs);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    end
    // Every lane-count code is trained in turn; the old code must stand meanwhile.
    prev = WIDTH_X1;
    for (i = 0; i < 7; i++) begin
      @(posedge aclk);
      err_in <= i[0];
      target_width <= widths[i];
      wait_train(1'b1);
      rd_word(OFF_LINK_CTRL_STAT, rd, rs);
      chk(rd, stat(prev, i[0], 1'b1, 8'h03));
      wait_train(1'b0);
      rd_word(OFF_LINK_CTRL_STAT, rd, rs);
      chk(rd, stat(widths[i], i[0], 1'b0, 8'h03));
      prev = widths[i];
    end
    conclude();
  end
endmodule : express_link_slot_cap_regs_tb
